/* File: bench/iwd_core_tb.sv */
// self-checking testbench of the watchdog in reset and interrupt builds
`timescale 1ns/100ps
`include "iwd_consts.svh"
module iwd_core_tb;
    // ****************************************************************
    // clock, reset and wiring
    // ****************************************************************
    localparam int PRE = 4; // short prescale keeps the run brief
    localparam int TKS = 5; // ticks per interval
    localparam int NOM = PRE * TKS; // nominal interval in cycles
    localparam int LO = NOM * 7 / 10; // thirty percent short
    localparam int HI = NOM * 13 / 10 + 3; // thirty percent long plus output latency
    localparam int GAP = LO - 4; // idle cycles between refreshes, inside the short interval
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1; // held on: the freeze path is not exercised here
    logic [`IWD_ADDR_W-1:0] io_addr;
    logic io_rd;
    logic io_wr;
    logic [`IWD_DATA_W-1:0] io_wdata;
    logic [`IWD_DATA_W-1:0] rdata_a;
    logic [`IWD_DATA_W-1:0] rdata_b;
    logic rvalid_a;
    logic host_rst_n;
    logic host_irq;
    logic [7:0] ra;
    logic [7:0] rb;
    logic rv;
    int checks = 0;
    int miscompares = 0;
    int lows = 0; // cycles seen with the host reset asserted

    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (host_rst_n === 1'b0) lows++;

    iwd_core #(.PRESCALE_CYC(PRE), .TIMEOUT_TICKS(TKS), .ACTION_IS_IRQ(1'b0)) i_dut (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .IO_ADDR(io_addr), .IO_RD(io_rd),
        .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(rdata_a), .IO_RVALID(rvalid_a),
        .HOST_RST_N(host_rst_n), .HOST_IRQ());
    // interrupt build shares the bus, so both actions see the same host traffic
    iwd_core #(.PRESCALE_CYC(PRE), .TIMEOUT_TICKS(TKS), .ACTION_IS_IRQ(1'b1)) i_dut_irq (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .IO_ADDR(io_addr), .IO_RD(io_rd),
        .IO_WR(io_wr), .IO_WDATA(io_wdata), .IO_RDATA(rdata_b), .IO_RVALID(),
        .HOST_RST_N(), .HOST_IRQ(host_irq));
    iwd_host_model i_host (
        .clk(clk_sys), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .rdata_a(rdata_a), .rdata_b(rdata_b), .rvalid_a(rvalid_a));

    // ****************************************************************
    // compare and report tasks
    // ****************************************************************
    task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_v

    // bench-side counts against an inclusive window
    task automatic cmp_n(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : cmp_n

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // expiry in both builds within the window; pulse width counted while contiguous
    task automatic expiry(input int lo, input int hi);
        int nr;
        int ni;
        int len;
        nr = -1;
        ni = -1;
        len = 0;
        for (int n = 1; n <= hi + 20; n++) begin
            @(negedge clk_sys);
            if (nr < 0 && host_rst_n === 1'b0) nr = n;
            if (nr > 0 && host_rst_n === 1'b0 && n - nr == len) len++;
            if (ni < 0 && host_irq === 1'b1) ni = n;
        end
        cmp_n(nr, lo, hi);
        cmp_n(ni, lo, hi);
        cmp_n(len, `IWD_RST_PULSE_CYC, `IWD_RST_PULSE_CYC);
        if (nr < 0 || ni < 0) summarize();
    endtask : expiry

    // disabled: no reset cycle and no interrupt over the span
    task automatic quiet(input int n);
        int l0;
        l0 = lows;
        repeat (n) @(negedge clk_sys);
        cmp_n(lows - l0, 0, 0);
        cmp_v({7'h00, host_irq}, 8'h00);
    endtask : quiet

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        cmp_v(rdata_a, 8'h00);
        cmp_v({7'h00, host_rst_n}, 8'h01);
        expiry(LO, HI);
        i_host.wr(`IWD_CTRL_PORT, 8'h00);
        quiet(4 * NOM);
        $display("test reset_default done");
        i_host.wr(`IWD_CTRL_PORT, 8'h01);
        expiry(LO, HI);
        i_host.wr(`IWD_CTRL_PORT, 8'h00);
        quiet(3 * NOM);
        $display("test write_enable done");
        // first read shows the state before its own enable; the disable write
        // was a port access, so the sticky expiry bit is already cleared
        i_host.rd(ra, rb, rv);
        cmp_v(ra, 8'h00);
        cmp_v(rb, 8'h04);
        cmp_v({7'h00, rv}, 8'h01);
        i_host.rd(ra, rb, rv);
        cmp_v(ra, 8'h01);
        cmp_v(rb, 8'h05);
        expiry(1, HI);
        // no access since the expiry, so the sticky bit shows; the read acknowledges
        i_host.rd(ra, rb, rv);
        cmp_v(ra, 8'h03);
        cmp_v(rb, 8'h07);
        cmp_v({7'h00, host_irq}, 8'h00);
        $display("test read_enable done");
        ra = 8'(lows);
        i_host.refresh(8, GAP);
        cmp_v(8'(lows), ra);
        // a clear aimed at a neighbouring address must not disable
        i_host.wr(16'h0442, 8'h00);
        // window counted from the last refresh: its gap and this write have elapsed
        expiry(LO - GAP - 2, HI - GAP - 2);
        $display("test refresh done");
        summarize();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
endmodule : iwd_core_tb

/* File: bench/iwd_host_model.sv */
// host cpu model that issues i/o port reads and writes toward the watchdog
`timescale 1ns/100ps
`include "iwd_consts.svh"
module iwd_host_model (
    input wire logic clk,
    output logic [`IWD_ADDR_W-1:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [`IWD_DATA_W-1:0] io_wdata,
    input wire logic [`IWD_DATA_W-1:0] rdata_a,
    input wire logic [`IWD_DATA_W-1:0] rdata_b,
    input wire logic rvalid_a
);
    // ****************************************************************
    // bus cycles, driven on the falling edge
    // ****************************************************************
    // idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end

    // one write strobe held across one rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        // released bus shows inverted values, so stale data cannot pass for good
        io_wdata = ~d;
        io_addr = ~a;
    endtask : wr

    // one read strobe; answer sampled in the cycle after the taking edge
    task automatic rd(output logic [7:0] da, output logic [7:0] db, output logic v);
        @(negedge clk);
        io_addr = `IWD_CTRL_PORT;
        io_rd = 1'b1;
        @(negedge clk);
        da = rdata_a;
        db = rdata_b;
        v = rvalid_a;
        io_rd = 1'b0;
        io_addr = 16'hbbbc;
    endtask : rd

    // periodic refresh, gap chosen by the caller well inside the short interval
    task automatic refresh(input int n, input int gap);
        repeat (n) begin
            wr(`IWD_CTRL_PORT, 8'h01);
            repeat (gap) @(negedge clk);
        end
    endtask : refresh
endmodule : iwd_host_model

/* File: logic/iwd_consts.svh */
// constants of the i/o port watchdog: addresses, field positions, reset values, timing
`ifndef IWD_CONSTS_SVH
`define IWD_CONSTS_SVH

// ****************************************************************
// host i/o decode
// ****************************************************************
`define IWD_ADDR_W 16
`define IWD_CTRL_PORT 16'h0443
`define IWD_DATA_W 8

// ****************************************************************
// control port fields (write) and status fields (read)
// ****************************************************************
`define IWD_CTL_EN_BIT 0
`define IWD_STS_EN_BIT 0
`define IWD_STS_EXP_BIT 1
`define IWD_STS_MODE_BIT 2
`define IWD_RDATA_RST 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define IWD_CLK_PERIOD_NS 50
`define IWD_TIMEOUT_MS 1600
`define IWD_TICK_NS 1000000
`define IWD_PRESCALE_CYC (`IWD_TICK_NS / `IWD_CLK_PERIOD_NS)
`define IWD_TIMEOUT_TICKS ((`IWD_TIMEOUT_MS * 1000000) / `IWD_TICK_NS)
`define IWD_RST_PULSE_CYC 16

`endif

/* File: logic/iwd_core.sv */
// i/o port watchdog timer: control port decode, timeout counter and expiry action
`timescale 1ns/100ps
`include "iwd_consts.svh"

// Notes on behaviour
// (RQ1) enabled and counting straight out of reset
// (RQ2) reading the control port enables the watchdog
// (RQ3) writing one enables and restarts the interval
// (RQ4) no refresh within interval resets the host
// (RQ5) writing zero disables, no action until re-enabled; a zero written during the host reset pulse is ignored
// (RQ6) expiry action is host reset or interrupt
// (RQ7) actual interval may deviate thirty percent
// (RQ8) host software refreshes about once per second
// (RQ9) prescaled counter; parameter picks reset or interrupt
module iwd_core #(
    parameter int PRESCALE_CYC = `IWD_PRESCALE_CYC,
    parameter int TIMEOUT_TICKS = `IWD_TIMEOUT_TICKS,
    parameter int RST_PULSE_CYC = `IWD_RST_PULSE_CYC,
    parameter bit ACTION_IS_IRQ = 1'b0
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic [`IWD_ADDR_W-1:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [`IWD_DATA_W-1:0] IO_WDATA,
    output logic [`IWD_DATA_W-1:0] IO_RDATA,
    output logic IO_RVALID,
    output logic HOST_RST_N,
    output logic HOST_IRQ
);
    // ****************************************************************
    // widths and elaboration checks
    // ****************************************************************
    localparam int TW = $clog2(TIMEOUT_TICKS + 1);
    localparam int PW = $clog2(RST_PULSE_CYC + 1);
    localparam logic [TW-1:0] T_LAST = TW'(TIMEOUT_TICKS - 1);
    localparam logic [PW-1:0] P_LAST = PW'(RST_PULSE_CYC - 1);

    if (TIMEOUT_TICKS < 2 || RST_PULSE_CYC < 1) begin : g_bad_par
        $error("timeout needs two ticks and reset pulse one cycle");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    iwd_pkg::iwd_state_t st_r; // current watchdog state
    logic [TW-1:0] tcnt_r; // ticks elapsed in this interval
    logic [PW-1:0] pcnt_r; // cycles of the host reset pulse
    logic exp_r; // sticky: an expiry has happened
    logic first_r; // high only until the first edge after reset
    logic sel; // address hits the control port
    logic rd_hit; // qualified read of the control port
    logic wr_hit; // qualified write of the control port
    logic wr_one; // write that enables and refreshes
    logic wr_zero; // write that disables
    logic expire; // last tick of the interval while running
    logic [`IWD_DATA_W-1:0] sts; // status byte returned on read

    iwd_tick_if tk ();

    // ****************************************************************
    // host port decode
    // ****************************************************************
    // strobes are one-cycle pulses from logic on this clock
    assign sel = (IO_ADDR == `IWD_CTRL_PORT);
    assign rd_hit = CE && sel && IO_RD;
    assign wr_hit = CE && sel && IO_WR;
    // only bit zero matters, so stray upper bits never disable the timer
    assign wr_one = wr_hit && IO_WDATA[`IWD_CTL_EN_BIT];
    assign wr_zero = wr_hit && !IO_WDATA[`IWD_CTL_EN_BIT];

    // expiry only while running; a refresh in the same cycle wins
    assign expire = CE && (st_r == iwd_pkg::IWD_RUN) && tk.tick && (tcnt_r == T_LAST) && !wr_hit; // [RQ4]

    // status byte: enable, sticky expiry, selected action
    always_comb begin
        sts = '0;
        sts[`IWD_STS_EN_BIT] = (st_r != iwd_pkg::IWD_OFF);
        sts[`IWD_STS_EXP_BIT] = exp_r;
        sts[`IWD_STS_MODE_BIT] = ACTION_IS_IRQ;
    end

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // a refresh or enable restarts the tick phase as well as the count
    assign tk.ce = CE;
    assign tk.clr = wr_one || (rd_hit && st_r == iwd_pkg::IWD_OFF) || (st_r != iwd_pkg::IWD_RUN); // [RQ3]

    iwd_prescaler #(
        .PRESCALE_CYC(PRESCALE_CYC)
    ) u_pre (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .tk(tk)
    );

    // ****************************************************************
    // state machine
    // ****************************************************************
    // reset lands in run, so no software action is needed to arm it
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= iwd_pkg::IWD_RUN; // [RQ1]
        end else if (CE) begin
            case (st_r)
                iwd_pkg::IWD_OFF: begin
                    if (wr_one || rd_hit) begin
                        st_r <= iwd_pkg::IWD_RUN; // [RQ2] [RQ3]
                    end
                end
                iwd_pkg::IWD_RUN: begin
                    if (wr_zero) begin
                        st_r <= iwd_pkg::IWD_OFF; // [RQ5]
                    end else if (expire && !ACTION_IS_IRQ) begin
                        st_r <= iwd_pkg::IWD_FIRE; // [RQ6]
                    end
                end
                iwd_pkg::IWD_FIRE: begin
                    // the pulse always finishes; host writes cannot cut it short
                    if (pcnt_r == P_LAST) begin
                        st_r <= iwd_pkg::IWD_RUN;
                    end
                end
                default: begin
                    st_r <= iwd_pkg::IWD_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // interval counter
    // ****************************************************************
    // exact count; the loose tolerance lets the tick be coarse
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            tcnt_r <= '0;
        end else if (CE) begin
            if (wr_hit || st_r != iwd_pkg::IWD_RUN || expire) begin
                tcnt_r <= '0; // [RQ3]
            end else if (tk.tick) begin
                tcnt_r <= tcnt_r + 1'b1; // [RQ7] [RQ9]
            end
        end
    end

    // ****************************************************************
    // host reset pulse
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pcnt_r <= '0;
            HOST_RST_N <= 1'b1;
        end else if (CE) begin
            if (expire && !ACTION_IS_IRQ) begin
                pcnt_r <= '0;
                HOST_RST_N <= 1'b0; // [RQ4] [RQ6]
            end else if (st_r == iwd_pkg::IWD_FIRE) begin
                pcnt_r <= pcnt_r + 1'b1;
                HOST_RST_N <= (pcnt_r == P_LAST);
            end else begin
                HOST_RST_N <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // interrupt request and sticky expiry flag
    // ****************************************************************
    // any port access acknowledges; a new expiry in that cycle wins
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_IRQ <= 1'b0;
            exp_r <= 1'b0;
        end else if (CE) begin
            if (expire) begin
                HOST_IRQ <= ACTION_IS_IRQ; // [RQ6]
                exp_r <= 1'b1;
            end else if (wr_hit || rd_hit) begin
                HOST_IRQ <= 1'b0;
                exp_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // status is captured before the read's own enable takes effect
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            IO_RDATA <= `IWD_RDATA_RST;
            IO_RVALID <= 1'b0;
        end else if (CE) begin
            IO_RVALID <= rd_hit;
            if (rd_hit) begin
                IO_RDATA <= sts;
            end
        end
    end

    // ****************************************************************
    // assertion helpers
    // ****************************************************************
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // cycles of the running interval, counted apart from the prescaler so the
    // tolerance check does not just restate the expiry decode
    localparam int NOM_CYC = PRESCALE_CYC * TIMEOUT_TICKS;
    localparam logic [31:0] LO_AGE = 32'(NOM_CYC * 7 / 10);
    localparam logic [31:0] HI_AGE = 32'(NOM_CYC * 13 / 10);
    logic [31:0] age_r; // enabled cycles since the interval restarted

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            age_r <= 32'h0000_0000;
        end else if (CE) begin
            if (wr_hit || st_r != iwd_pkg::IWD_RUN || expire) begin
                age_r <= 32'h0000_0000;
            end else begin
                age_r <= age_r + 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    sequence s_refresh;
        wr_one;
    endsequence

    sequence s_fire_start;
        expire && !ACTION_IS_IRQ;
    endsequence

    sequence s_pulse_low;
        !HOST_RST_N;
    endsequence

    property p_reset_enabled;
        first_r |-> (st_r == iwd_pkg::IWD_RUN);
    endproperty
    a_reset_enabled: assert property (p_reset_enabled) else $error("not enabled after reset"); // [RQ1]

    property p_read_enables;
        rd_hit && st_r == iwd_pkg::IWD_OFF |=> st_r == iwd_pkg::IWD_RUN;
    endproperty
    a_read_enables: assert property (p_read_enables) else $error("read did not enable"); // [RQ2]

    property p_write_one;
        s_refresh |=> (st_r != iwd_pkg::IWD_OFF) && (tcnt_r == '0);
    endproperty
    a_write_one: assert property (p_write_one) else $error("write one did not restart"); // [RQ3]

    property p_fire_pulse;
        s_fire_start |=> s_pulse_low;
    endproperty
    a_fire_pulse: assert property (p_fire_pulse) else $error("expiry without host reset"); // [RQ4]

    property p_write_zero;
        wr_zero && st_r != iwd_pkg::IWD_FIRE |=> st_r == iwd_pkg::IWD_OFF ##1 !expire;
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write zero did not disable"); // [RQ5]

    property p_action_kind;
        ACTION_IS_IRQ ? HOST_RST_N : !HOST_IRQ;
    endproperty
    a_action_kind: assert property (p_action_kind) else $error("wrong expiry action"); // [RQ6]

    property p_expire_count;
        expire |-> (age_r >= LO_AGE) && (age_r <= HI_AGE);
    endproperty
    a_expire_count: assert property (p_expire_count) else $error("expiry at wrong count"); // [RQ7]

    property p_irq_on_expire;
        expire && ACTION_IS_IRQ |=> HOST_IRQ && exp_r;
    endproperty
    a_irq_on_expire: assert property (p_irq_on_expire) else $error("interrupt not raised"); // [RQ9]

endmodule : iwd_core

/* File: logic/iwd_pkg.sv */
// types shared by the i/o port watchdog modules
package iwd_pkg;

    // ****************************************************************
    // watchdog states
    // ****************************************************************
    typedef enum logic [1:0] {
        IWD_OFF,  // disabled, no timeout action
        IWD_RUN,  // counting toward expiry
        IWD_FIRE  // host reset pulse in progress
    } iwd_state_t;

endpackage : iwd_pkg

/* File: logic/iwd_prescaler.sv */
// prescaler that turns the system clock into a slow tick for the watchdog
`timescale 1ns/100ps
`include "iwd_consts.svh"
module iwd_prescaler #(
    parameter int PRESCALE_CYC = `IWD_PRESCALE_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    iwd_tick_if.src tk
);
    localparam int CW = (PRESCALE_CYC > 1) ? $clog2(PRESCALE_CYC) : 1;
    localparam logic [CW-1:0] LAST = CW'(PRESCALE_CYC - 1);

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (PRESCALE_CYC < 1) begin : g_bad_pre
        $error("prescaler period must be at least one cycle");
    end

    logic [CW-1:0] cnt_r; // phase within one tick period

    // ****************************************************************
    // divider: clear restarts the phase so a refresh gets a full tick
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            tk.tick <= 1'b0;
        end else if (tk.ce) begin
            if (tk.clr) begin
                cnt_r <= '0; // [RQ9]
                tk.tick <= 1'b0;
            end else if (cnt_r == LAST) begin
                cnt_r <= '0; // [RQ9]
                tk.tick <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
                tk.tick <= 1'b0;
            end
        end
    end

endmodule : iwd_prescaler

/* File: logic/iwd_tick_if.sv */
// tick link between the prescaler and the watchdog core
`timescale 1ns/100ps
interface iwd_tick_if;
    logic ce;   // clock enable, freezes the prescaler while low
    logic clr;  // restart the prescaler phase
    logic tick; // one-cycle pulse per prescaler period

    modport src (input ce, input clr, output tick);
    modport dst (output ce, output clr, input tick);
endinterface : iwd_tick_if
